/* File: rtl/tcc_defs.svh */
// register map, field positions, reset values and timing counts for conversion control
// Overview of operation
// [RULE_01] main config bit 6 is standby: 1 halts periodic conversions, 0 converts at the selected interval
// [RULE_02] main config bits 1 and 0 enable fault queues of remotes 4 and 3, reset on
// [RULE_03] reserved bits of every configuration register always read back as zero
// [RULE_04] two-bit interval: continuous, 0.364 s, 1 s, 2.5 s; resets to 1 s
// [RULE_05] enabled channels convert in turn, then standby until the interval ends
// [RULE_06] a channel whose enable bit is clear is skipped, with no measurement
// [RULE_07] continuous mode shortens with skipped channels; other rates keep their interval
// [RULE_08] enable bits: remote 4..1 in bits 4..1, local in bit 0, all reset on
// [RULE_09] filter bits 3-2 select remote 2 filter: off, basic, enhanced; resets enhanced
// [RULE_10] filter bits 1-0 select remote 1 filter with the same coding; resets enhanced
// [RULE_11] host never writes filter code 10, which is reserved
// [RULE_12] in standby any single-shot write starts exactly one pass over enabled channels; the code ignores a write made while a pass is starting or running
// [RULE_13] the single-shot data byte is discarded; only the write itself counts
// [RULE_14] a single-shot write in active mode leaves the periodic schedule untouched
// [RULE_15] status bit 7 shows busy while a conversion is in progress
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

`define ADDR_COMMON_STATUS 8'h02
`define ADDR_MAIN_CONFIG   8'h03
`define ADDR_INTERVAL      8'h04
`define ADDR_CHANNEL_EN    8'h05
`define ADDR_FILTER        8'h06
`define ADDR_SINGLE_SHOT   8'h0f

`define BIT_SLEEP          6
`define BIT_BUSY           7
`define MASK_MAIN_CONFIG   8'h43
`define MASK_INTERVAL      8'h03
`define MASK_CHANNEL_EN    8'h1f
`define MASK_FILTER        8'h0f

`define RST_MAIN_CONFIG    8'h03
`define RST_INTERVAL       8'h02
`define RST_CHANNEL_EN     8'h1f
`define RST_FILTER         8'h0f

`define NUM_CHANNELS       5
`define CLK_PERIOD_NS      25
`define TICK_PERIOD_NS     1000
`define TICK_CYCLES        (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define INTERVAL_364_MS    364
`define INTERVAL_1000_MS   1000
`define INTERVAL_2500_MS   2500
`define CONV_TIME_US       28600
`define TICKS_PER_MS       1000

`endif

/* File: rtl/tcc_pkg.sv */
// types shared by conversion control modules
package tcc_pkg;
  typedef enum logic [1:0] {
    rate_continuous,
    rate_364ms,
    rate_1s,
    rate_2500ms
  } interval_e;

  typedef logic [4:0]  channel_mask_t;
  typedef logic [2:0]  channel_idx_t;
  typedef logic [21:0] tick_count_t;
endpackage : tcc_pkg

/* File: rtl/seq_if.sv */
// link between schedule control and the channel sequencer
`timescale 1ns/1ps
interface seq_if;
  import tcc_pkg::*;
  logic          tick;
  logic          start;
  channel_mask_t enables;
  logic          busy;
  logic          done;
  logic          conv_strobe;
  channel_idx_t  channel;

  modport ctrl (output tick, output start, output enables,
                input busy, input done, input conv_strobe, input channel);
  modport seq  (input tick, input start, input enables,
                output busy, output done, output conv_strobe, output channel);
endinterface : seq_if

/* File: rtl/conv_sequencer.sv */
// walks the enabled channels once per start, one conversion slot each
`timescale 1ns/1ps
`include "tcc_defs.svh"
module conv_sequencer #(
  parameter tcc_pkg::tick_count_t CONV_TICKS = 22'(`CONV_TIME_US)
) (
  input  wire logic clk,
  input  wire logic rst,
  seq_if.seq        sq
);
  import tcc_pkg::*;

  typedef enum logic [1:0] {st_idle, st_scan, st_convert} seq_state_e;

  localparam channel_idx_t LAST_CH = 3'(`NUM_CHANNELS - 1);

  seq_state_e  state;
  tick_count_t slot_cnt;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state          <= st_idle;
      sq.channel     <= '0;
      sq.busy        <= 1'b0;
      sq.done        <= 1'b0;
      sq.conv_strobe <= 1'b0;
      slot_cnt       <= '0;
    end else begin
      sq.done        <= 1'b0;
      sq.conv_strobe <= 1'b0;
      case (state)
        st_idle: begin
          if (sq.start) begin
            state      <= st_scan;
            sq.channel <= '0;
            sq.busy    <= 1'b1;  // RULE_15
          end
        end
        st_scan: begin
          if (sq.enables[sq.channel]) begin
            state          <= st_convert;
            slot_cnt       <= '0;
            sq.conv_strobe <= 1'b1;
          end else if (sq.channel == LAST_CH) begin  // RULE_06
            state   <= st_idle;
            sq.busy <= 1'b0;
            sq.done <= 1'b1;
          end else begin
            sq.channel <= sq.channel + 3'd1;  // RULE_06
          end
        end
        st_convert: begin
          if (sq.tick) begin
            if (slot_cnt == CONV_TICKS - 22'd1) begin
              if (sq.channel == LAST_CH) begin
                state   <= st_idle;
                sq.busy <= 1'b0;  // RULE_15
                sq.done <= 1'b1;
              end else begin
                state      <= st_scan;
                sq.channel <= sq.channel + 3'd1;  // RULE_05
              end
            end else begin
              slot_cnt <= slot_cnt + 22'd1;
            end
          end
        end
        default: begin
          state   <= st_idle;
          sq.busy <= 1'b0;
        end
      endcase
    end
  end
endmodule : conv_sequencer

/* File: rtl/temp_conversion_control.sv */
// configuration registers and conversion schedule of the temperature sensor
`timescale 1ns/1ps
`include "tcc_defs.svh"
module temp_conversion_control #(
  parameter tcc_pkg::tick_count_t CONV_TICKS    = 22'(`CONV_TIME_US),
  parameter tcc_pkg::tick_count_t TICKS_364MS   = 22'(`INTERVAL_364_MS * `TICKS_PER_MS),
  parameter tcc_pkg::tick_count_t TICKS_1S      = 22'(`INTERVAL_1000_MS * `TICKS_PER_MS),
  parameter tcc_pkg::tick_count_t TICKS_2500MS  = 22'(`INTERVAL_2500_MS * `TICKS_PER_MS)
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_rvalid,
  output logic                   soft_sleep_request,
  output logic                   remote4_queue_on,
  output logic                   remote3_queue_on,
  output logic      [1:0]        interval_select,
  output tcc_pkg::channel_mask_t channel_enables,
  output logic      [1:0]        remote2_filter_mode,
  output logic      [1:0]        remote1_filter_mode,
  output logic                   conv_busy,
  output logic                   conv_start,
  output tcc_pkg::channel_idx_t  conv_channel
);
  import tcc_pkg::*;

  localparam logic [5:0] TICK_LAST = 6'(`TICK_CYCLES - 1);

  seq_if sq ();

  logic [5:0]  tick_div;
  logic        tick;
  logic        start;
  tick_count_t interval_cnt;
  tick_count_t interval_len;
  logic        periodic_due;
  logic        single_shot_wr;
  logic        main_wr;
  logic        rate_wr;
  logic        enable_wr;
  logic        filter_wr;
  logic [7:0]  next_rdata;

  // reset images of the registers; only their defined bits are loaded
  localparam logic [7:0] MAIN_RST   = `RST_MAIN_CONFIG;
  localparam logic [7:0] RATE_RST   = `RST_INTERVAL;
  localparam logic [7:0] ENABLE_RST = `RST_CHANNEL_EN;
  localparam logic [7:0] FILTER_RST = `RST_FILTER;

  //////////////////////////////////////////////////////////////////////////////
  // register writes, one process per register
  assign main_wr   = reg_wr && (reg_addr == `ADDR_MAIN_CONFIG);
  assign rate_wr   = reg_wr && (reg_addr == `ADDR_INTERVAL);
  assign enable_wr = reg_wr && (reg_addr == `ADDR_CHANNEL_EN);
  assign filter_wr = reg_wr && (reg_addr == `ADDR_FILTER);
  // unmapped command bytes match none of the strobes and are dropped

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_sleep_request <= MAIN_RST[`BIT_SLEEP];  // RULE_01
      remote4_queue_on   <= MAIN_RST[1];  // RULE_02
      remote3_queue_on   <= MAIN_RST[0];  // RULE_02
    end else if (main_wr) begin
      soft_sleep_request <= reg_wdata[`BIT_SLEEP];  // RULE_01
      remote4_queue_on   <= reg_wdata[1];  // RULE_02
      remote3_queue_on   <= reg_wdata[0];  // RULE_02
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interval_select <= RATE_RST[1:0];  // RULE_04
    end else if (rate_wr) begin
      interval_select <= reg_wdata[1:0];  // RULE_04
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_enables <= ENABLE_RST[4:0];  // RULE_08
    end else if (enable_wr) begin
      channel_enables <= reg_wdata[4:0];  // RULE_08
    end
  end

  // reserved code 10 is stored as written; the host must not use it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remote2_filter_mode <= FILTER_RST[3:2];  // RULE_09
      remote1_filter_mode <= FILTER_RST[1:0];  // RULE_10
    end else if (filter_wr) begin
      remote2_filter_mode <= reg_wdata[3:2];  // RULE_09
      remote1_filter_mode <= reg_wdata[1:0];  // RULE_10
    end
  end

  // single-shot data is never stored, only the strobe is used
  assign single_shot_wr = reg_wr && (reg_addr == `ADDR_SINGLE_SHOT);  // RULE_13

  //////////////////////////////////////////////////////////////////////////////
  // register reads, one cycle after the strobe; reserved bits are forced low
  always_comb begin
    case (reg_addr)
      `ADDR_COMMON_STATUS: next_rdata = {sq.busy, 7'h00};  // RULE_15
      `ADDR_MAIN_CONFIG:
        next_rdata = {1'b0, soft_sleep_request, 4'h0,
                      remote4_queue_on, remote3_queue_on};  // RULE_03
      `ADDR_INTERVAL:      next_rdata = {6'h00, interval_select};  // RULE_03
      `ADDR_CHANNEL_EN:    next_rdata = {3'h0, channel_enables};  // RULE_03
      `ADDR_FILTER:
        next_rdata = {4'h0, remote2_filter_mode, remote1_filter_mode};  // RULE_03
      // the single-shot register is write-only and reads as zero
      default:             next_rdata = 8'h00;  // RULE_13
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // read data holds until the next read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // microsecond tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_div <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_div == TICK_LAST);
      tick_div <= (tick_div == TICK_LAST) ? 6'd0 : tick_div + 6'd1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interval timer; runs freely in active mode so skipped channels become standby
  always_comb begin
    case (interval_e'(interval_select))
      rate_364ms:  interval_len = TICKS_364MS;
      rate_1s:     interval_len = TICKS_1S;
      rate_2500ms: interval_len = TICKS_2500MS;
      default:     interval_len = TICKS_1S;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interval_cnt <= '0;
      periodic_due <= 1'b0;
    end else if (soft_sleep_request) begin
      interval_cnt <= '0;  // RULE_01
      periodic_due <= 1'b0;
    end else begin
      if (start) begin
        periodic_due <= 1'b0;
      end
      if (tick) begin
        if (interval_cnt >= interval_len - 22'd1) begin
          interval_cnt <= '0;
          periodic_due <= 1'b1;  // RULE_07
        end else begin
          interval_cnt <= interval_cnt + 22'd1;  // RULE_05
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pass launch: guarded by busy and by the previous start so one request is one pass
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start <= 1'b0;
    end else if (start || sq.busy) begin
      start <= 1'b0;
    end else if (soft_sleep_request) begin
      start <= single_shot_wr;  // RULE_12
    end else if (interval_e'(interval_select) == rate_continuous) begin
      start <= 1'b1;  // RULE_07
    end else begin
      // an active-mode single-shot write falls through here unused
      start <= periodic_due;  // RULE_14
    end
  end

  assign sq.tick    = tick;
  assign sq.start   = start;
  assign sq.enables = channel_enables;

  conv_sequencer #(.CONV_TICKS(CONV_TICKS)) u_seq (
    .clk (clk),
    .rst (rst),
    .sq  (sq.seq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs to the converter, re-timed so every port leaves a flop
  // conv_channel only means something while conv_busy is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_busy    <= 1'b0;
      conv_start   <= 1'b0;
      conv_channel <= '0;
    end else begin
      conv_busy    <= sq.busy;  // RULE_15
      conv_start   <= sq.conv_strobe;  // RULE_06
      conv_channel <= sq.channel;
    end
  end
endmodule : temp_conversion_control

/* File: verification/tcc_host.sv */
// host model issuing single-byte register writes and reads
`timescale 1ns/1ps
module tcc_host (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  initial begin
    reg_addr  = 8'hff;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // idle bus shows inverted leftovers so stale values never pass as valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h06) d = d | ((d >> 1) & 8'h05);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(posedge clk) #1;
    if (reg_rvalid === 1'b1) d = reg_rdata;
  endtask : rd
endmodule : tcc_host

/* File: verification/tcc_asserts.sv */
// port assertions for the conversion control block
`timescale 1ns/1ps
module tcc_asserts (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic [7:0]             reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  input wire logic                   soft_sleep_request,
  input wire logic                   remote4_queue_on,
  input wire logic                   remote3_queue_on,
  input wire logic [1:0]             interval_select,
  input wire tcc_pkg::channel_mask_t channel_enables,
  input wire logic [1:0]             remote2_filter_mode,
  input wire logic [1:0]             remote1_filter_mode,
  input wire logic                   conv_busy,
  input wire logic                   conv_start,
  input wire tcc_pkg::channel_idx_t  conv_channel
);
  import tcc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr(a);
    reg_wr && reg_addr == a;
  endsequence
  a_sleep_bit: assert property (s_wr(8'h03) |=> soft_sleep_request == $past(reg_wdata[6]))
    else $error("standby bit not taken");
  a_queue_bits: assert property (s_wr(8'h03)
    |=> {remote4_queue_on, remote3_queue_on} == $past(reg_wdata[1:0])) else $error("queue bits");
  a_interval_bits: assert property (s_wr(8'h04) |=> interval_select == $past(reg_wdata[1:0]))
    else $error("interval field");
  a_enable_bits: assert property (s_wr(8'h05) |=> channel_enables == $past(reg_wdata[4:0]))
    else $error("enable field");
  a_filter_bits: assert property (s_wr(8'h06)
    |=> {remote2_filter_mode, remote1_filter_mode} == $past(reg_wdata[3:0])) else $error("filter");
  a_reserved_zero: assert property (reg_rd && reg_addr == 8'h03 |=> (reg_rdata & 8'hbc) == 8'h00)
    else $error("reserved bits set");
  a_skip_off: assert property (conv_start |-> channel_enables[conv_channel])
    else $error("disabled channel converted");
  a_busy_slot: assert property (conv_start |=> conv_busy [*8])
    else $error("busy dropped in slot");
  a_slot_gap: assert property (conv_start |=> !conv_start [*8])
    else $error("slots overlap");
endmodule : tcc_asserts
bind temp_conversion_control tcc_asserts chk (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .soft_sleep_request, .remote4_queue_on, .remote3_queue_on, .interval_select,
  .channel_enables, .remote2_filter_mode, .remote1_filter_mode, .conv_busy, .conv_start,
  .conv_channel);

/* File: verification/temp_conversion_control_bench.sv */
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module temp_conversion_control_bench;
  import tcc_pkg::*;
  logic          clk, rst, reg_wr, reg_rd, reg_rvalid, pb;
  logic          soft_sleep_request, remote4_queue_on, remote3_queue_on, conv_busy, conv_start;
  logic [7:0]    reg_addr, reg_wdata, reg_rdata, d;
  logic [1:0]    interval_select, remote2_filter_mode, remote1_filter_mode;
  channel_mask_t channel_enables;
  channel_idx_t  conv_channel;
  int            n_errors = 0, checked = 0, cyc = 0, starts[$], rise_at[$];
  int            tk[4] = '{0, 20, 30, 40};
  logic [7:0]    ref_regs [3:6] = '{8'h03, 8'h02, 8'h1f, 8'h0f};
  logic [7:0]    rnd = 8'h17;
  // short counts keep the run small; expectations follow them
  temp_conversion_control #(.CONV_TICKS(22'd4), .TICKS_364MS(22'd20), .TICKS_1S(22'd30),
    .TICKS_2500MS(22'd40)) dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid, .soft_sleep_request, .remote4_queue_on, .remote3_queue_on, .interval_select,
    .channel_enables, .remote2_filter_mode, .remote1_filter_mode, .conv_busy, .conv_start,
    .conv_channel);
  tcc_host host (.clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [7:0] mask(input logic [7:0] a);
    return a == 8'h03 ? 8'h43 : a == 8'h04 ? 8'h03 : a == 8'h05 ? 8'h1f : 8'h0f;
  endfunction : mask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic conclude;
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic put(input logic [7:0] a, input logic [7:0] v);
    if (a == 8'h06) v = v | ((v >> 1) & 8'h05);
    host.wr(a, v);
    if (a inside {[8'h03:8'h06]}) ref_regs[a] = v;
  endtask : put
  task automatic chk(input logic [7:0] a);
    host.rd(a, d);
    cmp(d, (a inside {[8'h03:8'h06]}) ? ref_regs[a] & mask(a) : 8'h00);
  endtask : chk
  task automatic pins;
    cmp({1'b0, soft_sleep_request, 4'h0, remote4_queue_on, remote3_queue_on}, ref_regs[3] & 8'h43);
    cmp({6'h0, interval_select}, ref_regs[4] & 8'h03);
    cmp({3'h0, channel_enables}, ref_regs[5] & 8'h1f);
    cmp({4'h0, remote2_filter_mode, remote1_filter_mode}, ref_regs[6] & 8'h0f);
  endtask : pins
  // a bound that runs out is reported as a mismatch and ends the run
  task automatic wait_busy(input logic lvl, input int lim);
    for (int i = 0; i < lim && conv_busy !== lvl; i++) @(posedge clk) #1;
    cmp({7'h0, conv_busy}, {7'h0, lvl});
    if (conv_busy !== lvl) conclude();
  endtask : wait_busy
  task automatic wait_rise(input int n);
    for (int i = 0; i < 4000 && rise_at.size() < n; i++) @(posedge clk) #1;
    cmp(8'(rise_at.size()), 8'(n));
    if (rise_at.size() < n) conclude();
  endtask : wait_rise
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pb  <= conv_busy;
    if (conv_start === 1'b1) starts.push_back(int'(conv_channel));
    if (conv_busy === 1'b1 && pb === 1'b0) rise_at.push_back(cyc);
  end
  initial begin
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    pins();
    for (int a = 2; a <= 16; a++) chk(8'(a));
    put(8'h03, 8'h40);
    repeat (16) begin
      rnd = lfsr(rnd);
      put(8'h03 + {6'h0, rnd[1:0]}, lfsr(rnd) | (rnd[1:0] == 2'b00 ? 8'h40 : 8'h00));
      pins();
      chk(8'h03 + {6'h0, rnd[1:0]});
    end
    put(8'h05, 8'h15);
    starts = {};
    put(8'h0f, 8'h5a);
    wait_busy(1'b1, 8);
    host.rd(8'h02, d);
    cmp(d, 8'h80);
    put(8'h0f, 8'h00);
    wait_busy(1'b0, 1000);
    repeat (1300) @(posedge clk);
    cmp(8'(starts.size()), 8'd3);
    foreach (starts[i]) cmp(8'(starts[i]), 8'(2 * i));
    for (int k = 0; k < 2; k++) begin
      put(8'h04, 8'h00);
      put(8'h05, k ? 8'h1f : 8'h01);
      put(8'h03, 8'h00);
      rise_at = {};
      repeat (1000) @(posedge clk);
      put(8'h03, 8'h40);
      cmp(8'(k ? rise_at.size() <= 2 : rise_at.size() >= 5), 8'd1);
      wait_busy(1'b0, 1000);
    end
    put(8'h05, 8'h03);
    for (int r = 1; r < 4; r++) begin
      put(8'h04, 8'(r));
      put(8'h03, 8'h00);
      rise_at = {};
      wait_rise(1);
      wait_busy(1'b0, 1000);
      put(8'h0f, 8'h77);
      wait_rise(2);
      cmp(8'((rise_at[1] - rise_at[0]) / 40), 8'(tk[r]));
      put(8'h03, 8'h40);
      wait_busy(1'b0, 1000);
    end
    conclude();
  end
endmodule : temp_conversion_control_bench
